// [logic/irq_guard_pkg.sv]
package irq_guard_pkg;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam int          ADDR_W       = 8;     // Register address width
	localparam int          DATA_W       = 8;     // Register data width
	localparam logic [7:0]  PIN_CFG_OFS  = 8'h7d; // Interrupt pin configuration
	localparam logic [7:0]  KEY_OFS      = 8'h7e; // Write protection key

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [7:0]  PIN_CFG_RST  = 8'h02; // Interrupt mode, shared drive, active low
	localparam logic [7:0]  KEY_RST      = 8'h85; // Fully unprotected after reset

	// ==========================================================
	// Key encodings
	// ==========================================================
	localparam logic [7:0]  KEY_FULL     = 8'h85; // Any number of writes
	localparam logic [7:0]  KEY_SINGLE   = 8'h86; // One write, then locked
	localparam logic [7:0]  KEY_LOCKED   = 8'h00; // Value left after a single write

	// ==========================================================
	// Field positions of the pin configuration register
	// ==========================================================
	localparam int          FN_SEL_BIT   = 2;     // pin_function_select
	localparam int          DRIVE_BIT    = 1;     // Drive only while asserted
	localparam int          POL_BIT      = 0;     // Asserted level
	localparam logic [7:0]  PIN_CFG_MASK = 8'h07; // Implemented bits

	// Pin configuration carried as one bundle
	typedef struct packed {
		logic fn_sel;    // 1: general-purpose output
		logic drive_sel; // 1: drive only while asserted
		logic polarity;  // Asserted level
	} pin_cfg_t;

	// Protection state decoded from the key
	typedef enum logic [1:0] {
		PROT_LOCKED,
		PROT_OPEN,
		PROT_ONCE
	} prot_state_t;

endpackage : irq_guard_pkg

// [logic/irq_pin_drive.sv]
module irq_pin_drive
	import irq_guard_pkg::*;
(
	input  wire logic     mclk,        // Register interface clock
	input  wire logic     sys_rst,     // Asynchronous reset, active high
	input  wire logic     clk_en,      // Freezes all state while low
	input  wire pin_cfg_t cfg,         // Current pin configuration
	input  wire logic     irq_req,     // Interrupt pending from the sources
	output logic          irq_pin_out, // Level put on the pin
	output logic          irq_pin_oe   // High while the pin is driven
);

	// ==========================================================
	// Pin level and enable selection
	// ==========================================================
	wire logic asserted;   // Pin is in its asserted state
	wire logic next_level; // Level to drive next
	wire logic next_oe;    // Enable to drive next

	// In output mode the pin simply sits at the polarity level
	assign asserted   = cfg.fn_sel | irq_req;
	assign next_level = asserted ? cfg.polarity : ~cfg.polarity;
	assign next_oe    = ~cfg.drive_sel | asserted;

	// ==========================================================
	// Output flip-flops
	// ==========================================================
	// Reset shows the default: inactive high, pin released
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_pin_out <= 1'b1;
			irq_pin_oe  <= 1'b0;
		end else if (clk_en) begin
			irq_pin_out <= next_level;
			irq_pin_oe  <= next_oe;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	chk_gpo_level: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && cfg.fn_sel) |=> (irq_pin_out == $past(cfg.polarity)))
		else $error("output mode pin level differs from polarity");

	chk_shared_release: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && cfg.drive_sel && !cfg.fn_sel && !irq_req) |=> !irq_pin_oe)
		else $error("shared pin driven while inactive");

	chk_always_driven: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && !cfg.drive_sel) |=> irq_pin_oe)
		else $error("pin released in always driven mode");

	chk_irq_polarity: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && !cfg.fn_sel) |=> (irq_pin_out == ($past(irq_req) ~^ $past(cfg.polarity))))
		else $error("interrupt level does not follow polarity");

endmodule // irq_pin_drive

// [logic/irq_pin_cfg_write_guard.sv]
// What this block does
// - Function bit picks interrupt or output pin
// - Drive bit: always driven or only asserted
// - Polarity bit picks asserted pin level
// - Key 85 open, 86 once, else locked
// - Fully open accepts unlimited writes
module irq_pin_cfg_write_guard
	import irq_guard_pkg::*;
#(
	parameter int ADDR_WIDTH = ADDR_W, // Register address width
	parameter int DATA_WIDTH = DATA_W  // Register data width
)(
	input  wire logic                  mclk,        // Register interface clock
	input  wire logic                  sys_rst,     // Asynchronous reset, active high
	input  wire logic                  clk_en,      // Freezes all state while low
	input  wire logic                  wr_en,       // Write strobe from the serial port
	input  wire logic [ADDR_WIDTH-1:0] wr_addr,     // Write address
	input  wire logic [DATA_WIDTH-1:0] wr_data,     // Write data
	input  wire logic                  rd_en,       // Read strobe from the serial port
	input  wire logic [ADDR_WIDTH-1:0] rd_addr,     // Read address
	input  wire logic                  irq_req,     // Interrupt pending from the sources
	output logic      [DATA_WIDTH-1:0] rd_data,     // Read data, one cycle after rd_en
	output logic                       rd_valid,    // Read data valid pulse
	output logic                       fwd_wr_en,   // Accepted write to another register
	output logic      [ADDR_WIDTH-1:0] fwd_addr,    // Its address
	output logic      [DATA_WIDTH-1:0] fwd_data,    // Its data
	output logic                       wr_blocked,  // Pulse: a write was refused
	output logic                       irq_pin_out, // Level put on the interrupt pin
	output logic                       irq_pin_oe   // High while the pin is driven
);

	// ==========================================================
	// Elaboration checks
	// ==========================================================
	if (ADDR_WIDTH != ADDR_W || DATA_WIDTH != DATA_W) begin : g_bad_width
		$error("register map needs 8-bit address and data");
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	// Map a key value onto the protection state
	function automatic prot_state_t decode_key(input logic [7:0] key);
		prot_state_t st;
		st = PROT_LOCKED;
		case (key)
			KEY_FULL:   st = PROT_OPEN;
			KEY_SINGLE: st = PROT_ONCE;
			default:    st = PROT_LOCKED;
		endcase
		return st;
	endfunction

	// ==========================================================
	// Registers
	// ==========================================================
	logic [7:0] pin_cfg; // Interrupt pin configuration
	logic [7:0] key;     // Write protection key

	// ==========================================================
	// Write decode and guard
	// ==========================================================
	prot_state_t      state;        // Present protection state
	wire logic        hit_key;      // Write aims at the key
	wire logic        hit_other;    // Write aims at any other register
	wire logic        other_ok;     // Guarded write is let through
	wire logic        other_refuse; // Guarded write is refused
	wire logic        cfg_wr;       // Accepted write to the pin configuration
	wire logic        relock;       // Single write consumed
	wire logic [7:0]  next_key;     // Key after this cycle
	wire logic [7:0]  next_pin_cfg; // Pin configuration after this cycle
	wire pin_cfg_t    cfg_bus;      // Pin configuration fields

	// Only one write port exists, so a key write and a guarded write
	// never meet in one cycle and the relock cannot race a fresh key.
	// In single mode the consumed write may go to any non-key address,
	// the pin configuration included.
	assign state        = decode_key(key);
	assign hit_key      = wr_en && (wr_addr == KEY_OFS);
	assign hit_other    = wr_en && (wr_addr != KEY_OFS);
	// The key itself is always writable, so software can unlock first
	assign other_ok     = hit_other && (state != PROT_LOCKED);
	assign other_refuse = hit_other && (state == PROT_LOCKED);
	assign cfg_wr       = other_ok && (wr_addr == PIN_CFG_OFS);
	assign relock       = other_ok && (state == PROT_ONCE);
	assign next_key     = hit_key ? wr_data : (relock ? KEY_LOCKED : key);
	assign next_pin_cfg = cfg_wr ? (wr_data & PIN_CFG_MASK) : pin_cfg;
	assign cfg_bus      = '{fn_sel:    pin_cfg[FN_SEL_BIT],
	                        drive_sel: pin_cfg[DRIVE_BIT],
	                        polarity:  pin_cfg[POL_BIT]};

	// Register storage
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_cfg <= PIN_CFG_RST;
			key     <= KEY_RST;
		end else if (clk_en) begin
			pin_cfg <= next_pin_cfg;
			key     <= next_key;
		end
	end

	// Accepted writes to other registers are passed on; refusals flagged
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fwd_wr_en  <= 1'b0;
			fwd_addr   <= '0;
			fwd_data   <= '0;
			wr_blocked <= 1'b0;
		end else if (clk_en) begin
			fwd_wr_en  <= other_ok;
			fwd_addr   <= wr_addr;
			fwd_data   <= wr_data;
			wr_blocked <= other_refuse;
		end
	end

	// ==========================================================
	// Read path
	// ==========================================================
	wire logic [7:0] next_rd_data; // Selected read value

	// Unmapped addresses read as zero
	// A read in the cycle of a write returns the value before it
	assign next_rd_data = (rd_addr == PIN_CFG_OFS) ? pin_cfg :
	                      (rd_addr == KEY_OFS)     ? key     : 8'h00;

	// Registered read answer
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data  <= '0;
			rd_valid <= 1'b0;
		end else if (clk_en) begin
			rd_data  <= rd_en ? next_rd_data : rd_data;
			rd_valid <= rd_en;
		end
	end

	// ==========================================================
	// Pin driver
	// ==========================================================
	irq_pin_drive u_pin (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.clk_en      (clk_en),
		.cfg         (cfg_bus),
		.irq_req     (irq_req),
		.irq_pin_out (irq_pin_out),
		.irq_pin_oe  (irq_pin_oe)
	);

	// ==========================================================
	// Checks: write guard
	// ==========================================================
	// A refused write leaves storage alone and raises the refusal pulse
	chk_locked_refuse: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && hit_other && key != KEY_FULL && key != KEY_SINGLE)
		|=> (!fwd_wr_en && wr_blocked && $stable(pin_cfg)))
		else $error("write passed while protected");

	// Fully open keeps the key and passes every write
	chk_open_accept: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && hit_other && key == KEY_FULL) |=> (fwd_wr_en && key == KEY_FULL))
		else $error("fully open write refused or key changed");

	// The single write passes, the key drops to locked, the next one is refused
	chk_once_relock: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && hit_other && key == KEY_SINGLE)
		|=> (fwd_wr_en && key == KEY_LOCKED)
		##1 (!(clk_en && hit_other) || !other_ok || $past(hit_key)))
		else $error("single write did not relock");

	// The single write is forwarded with its own address and data
	chk_once_forward: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && hit_other && key == KEY_SINGLE)
		|=> (fwd_addr == $past(wr_addr) && fwd_data == $past(wr_data)))
		else $error("single write forwarded wrongly");

	// Key writes are never refused
	chk_key_write: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && hit_key) |=> (key == $past(wr_data) && !fwd_wr_en))
		else $error("key write not taken");

	// Without a write the key keeps its value
	chk_key_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && !wr_en) |=> $stable(key))
		else $error("key changed without a write");

	// No guarded write, no forward and no refusal pulse
	chk_fwd_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && !hit_other) |=> (!fwd_wr_en && !wr_blocked))
		else $error("write pulse without a guarded write");

	// Accepted pin configuration writes land with spare bits cleared
	chk_cfg_update: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && wr_en && wr_addr == PIN_CFG_OFS && key == KEY_FULL)
		|=> (pin_cfg == ($past(wr_data) & PIN_CFG_MASK)))
		else $error("pin configuration not updated");

	// ==========================================================
	// Checks: read path and clock enable
	// ==========================================================
	// The key reads back one cycle after the strobe
	chk_read_answer: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && rd_en && rd_addr == KEY_OFS && !wr_en) |=> (rd_valid && rd_data == key))
		else $error("key read back wrong");

	// The pin configuration reads back one cycle after the strobe
	chk_cfg_read: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && rd_en && rd_addr == PIN_CFG_OFS && !wr_en)
		|=> (rd_valid && rd_data == pin_cfg))
		else $error("pin configuration read back wrong");

	// Without a read strobe the valid pulse drops and the data hold
	chk_read_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && !rd_en) |=> (!rd_valid && $stable(rd_data)))
		else $error("read answer without a read");

	// A low clock enable freezes both registers, the write pulses and the read answer
	chk_freeze_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!clk_en |=> ($stable(key) && $stable(pin_cfg) && $stable(fwd_wr_en)
		             && $stable(wr_blocked) && $stable(rd_valid) && $stable(rd_data)))
		else $error("state moved while clock enable low");

	// Spare configuration bits are never stored
	chk_spare_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		(pin_cfg & ~PIN_CFG_MASK) == 8'h00)
		else $error("spare configuration bits set");

endmodule // irq_pin_cfg_write_guard

// [testbench/irq_pin_cfg_write_guard_tb.sv]
module irq_pin_cfg_write_guard_tb
	import irq_guard_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Stimulus and observed signals
	// ==========================================================
	logic       mclk        = 1'b0;  // Register interface clock
	logic       sys_rst     = 1'b1;  // Reset, active high
	logic       clk_en      = 1'b1;  // Clock enable, dropped only in t_freeze
	logic       wr_en       = 1'b0;  // Write strobe
	logic [7:0] wr_addr     = 8'h00; // Write address
	logic [7:0] wr_data     = 8'h00; // Write data
	logic       rd_en       = 1'b0;  // Read strobe
	logic [7:0] rd_addr     = 8'h00; // Read address
	logic       irq_req     = 1'b0;  // Pending interrupt
	logic [7:0] rd_data;             // Read value
	logic       rd_valid;            // Read valid pulse
	logic       fwd_wr_en;           // Accepted write pulse
	logic [7:0] fwd_addr;            // Accepted address
	logic [7:0] fwd_data;            // Accepted data
	logic       wr_blocked;          // Refused write pulse
	logic       irq_pin_out;         // Pin level
	logic       irq_pin_oe;          // Pin drive enable
	int         num_errors  = 0;     // Mismatches seen
	int         num_checks  = 0;     // Comparisons made
	int         cycles      = 0;     // Cycle counter for the timeout

	irq_pin_cfg_write_guard u_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
		.irq_req(irq_req), .rd_data(rd_data), .rd_valid(rd_valid), .fwd_wr_en(fwd_wr_en),
		.fwd_addr(fwd_addr), .fwd_data(fwd_data), .wr_blocked(wr_blocked),
		.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));

	// Clock, 4 ns period
	always #2 mclk = ~mclk;

	// ==========================================================
	// Shared tasks
	// ==========================================================
	// Compare and report
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Print counts and verdict, then stop
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	// One write; returns just after the edge that answers it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(posedge mclk);
		#1;
		wr_en = 1'b0;
	endtask

	// One read, compared against the expected value
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		#1;
		rd_en = 1'b1;
		rd_addr = a;
		@(posedge mclk);
		#1;
		rd_en = 1'b0;
		check({7'h00, rd_valid}, 8'h01);
		check(rd_data, exp);
	endtask

	// Write and judge acceptance
	task automatic wr_exp(input logic [7:0] a, input logic [7:0] d, input logic ok);
		wr(a, d);
		check({7'h00, fwd_wr_en}, {7'h00, ok});
		check({7'h00, wr_blocked}, {7'h00, ~ok});
		if (ok) check(fwd_addr, a);
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	// Reset values and an unmapped read
	task automatic t_reset;
		check({7'h00, irq_pin_oe}, 8'h00);
		rd(PIN_CFG_OFS, 8'h02);
		rd(KEY_OFS, 8'h85);
		rd(8'h40, 8'h00);
	endtask

	// Every class of key value, boundaries included
	task automatic t_key_decode;
		logic [7:0] keys [6];
		keys = '{8'h00, 8'h84, 8'h85, 8'h86, 8'h87, 8'hff};
		foreach (keys[i]) begin
			wr(KEY_OFS, keys[i]);
			wr_exp(PIN_CFG_OFS, 8'h03, keys[i] == 8'h85 || keys[i] == 8'h86);
		end
	endtask

	// Single mode: one write, then locked
	task automatic t_single;
		wr(KEY_OFS, KEY_SINGLE);
		wr_exp(8'h40, 8'h5a, 1'b1);
		wr_exp(PIN_CFG_OFS, 8'h01, 1'b0);
		wr(KEY_OFS, KEY_SINGLE);
		wr_exp(PIN_CFG_OFS, 8'h05, 1'b1);
		wr_exp(PIN_CFG_OFS, 8'h01, 1'b0);
		rd(PIN_CFG_OFS, 8'h05);
		rd(KEY_OFS, KEY_LOCKED);
	endtask

	// Fully open: several writes all taken
	task automatic t_full;
		wr(KEY_OFS, KEY_FULL);
		wr_exp(PIN_CFG_OFS, 8'hff, 1'b1);
		rd(PIN_CFG_OFS, PIN_CFG_MASK);
		wr_exp(8'h40, 8'ha5, 1'b1);
		check(fwd_data, 8'ha5);
		wr_exp(PIN_CFG_OFS, 8'h06, 1'b1);
		rd(PIN_CFG_OFS, 8'h06);
		rd(KEY_OFS, KEY_FULL);
	endtask

	// Every pin configuration with the interrupt idle and pending
	task automatic t_pin;
		logic as;
		logic eoe;
		for (int c = 0; c < 8; c++) begin
			for (int i = 0; i < 2; i++) begin
				wr(PIN_CFG_OFS, c[7:0]);
				irq_req = i[0];
				repeat (2) @(posedge mclk);
				#1;
				as = c[FN_SEL_BIT] | i[0];
				eoe = ~c[DRIVE_BIT] | as;
				check({7'h00, irq_pin_oe}, {7'h00, eoe});
				if (eoe) check({7'h00, irq_pin_out}, {7'h00, as ? c[0] : ~c[0]});
			end
		end
		irq_req = 1'b0;
	endtask

	// A low clock enable holds both registers, the write and read pulses and the pin
	task automatic t_freeze;
		wr(PIN_CFG_OFS, PIN_CFG_RST);
		@(posedge mclk);
		#1;
		clk_en = 1'b0;
		wr_en = 1'b1;
		wr_addr = PIN_CFG_OFS;
		wr_data = 8'h04;
		rd_en = 1'b1;
		rd_addr = KEY_OFS;
		irq_req = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		check({6'h00, fwd_wr_en, wr_blocked}, 8'h00);
		check({6'h00, rd_valid, irq_pin_oe}, 8'h00);
		check({7'h00, irq_pin_out}, 8'h01);
		clk_en = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		irq_req = 1'b0;
		rd(PIN_CFG_OFS, PIN_CFG_RST);
		rd(KEY_OFS, KEY_FULL);
	endtask

	// A reset in mid-run restores the defaults
	task automatic t_midreset;
		wr_exp(PIN_CFG_OFS, 8'h05, 1'b1);
		wr(KEY_OFS, KEY_LOCKED);
		@(posedge mclk);
		#1;
		sys_rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		check({6'h00, irq_pin_oe, irq_pin_out}, 8'h01);
		check({6'h00, fwd_wr_en, rd_valid}, 8'h00);
		rd(PIN_CFG_OFS, PIN_CFG_RST);
		rd(KEY_OFS, KEY_RST);
		wr_exp(8'h40, 8'h3c, 1'b1);
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		t_reset();
		t_key_decode();
		t_single();
		t_full();
		t_pin();
		t_freeze();
		t_midreset();
		tally_and_finish();
	end

endmodule // irq_pin_cfg_write_guard_tb
